// ==== hw/plrpd_cfg.svh ====
// Constants of the reference divider, phase detector and prescaler block.
// Summary of operation
// - Mode 001 runs oscillator, counter unless standby.
// - Crystal mode standby: oscillator runs, counter stopped.
// - Mode zero stops oscillator, standby or not.
// - Mode seven: output is input divided by 16.
// - Mode three: output follows input one-to-one.
// - Reset selects divide-by-eight output ratio.
// - Mode two: input works, output held off.
// - Normal polarity: lead sinks, lag sources, else float.
// - Polarity bit swaps source/sink and double outputs.
// - Lead pulses vco side low, lag reference side.
// - Select bit clear floats single-ended output.
// - Standby floats single-ended output.
// - Select high or standby holds double outputs high.
// - Lock output is AND of double outputs.
// - Reset disables lock output, holding it low.
// - Current scaled by select bits and step bit.
// - Prescaler divides 65 when low, 64 high.
// - Select high: single enabled, doubles high; resets low.
// - Lock enable low forces lock output low.
// - Step low 70-100 percent, high 25-100 percent.
// - Polarity bit clears at reset.
`ifndef PLRPD_CFG_SVH
`define PLRPD_CFG_SVH
`define PLRPD_AW 8
`define PLRPD_OFS_CTRL 8'h00
`define PLRPD_OFS_MODE 8'h04
`define PLRPD_OFS_STAT 8'h08
`define PLRPD_CTRL_RST 8'h00
`define PLRPD_MODE_RST 3'h6
`define PLRPD_MODE_SHUT 3'h0
`define PLRPD_MODE_XTAL 3'h1
`define PLRPD_MODE_OFF 3'h2
`define PLRPD_MODE_FOLLOW 3'h3
`define PLRPD_MODE_DIV2 3'h4
`define PLRPD_MODE_DIV4 3'h5
`define PLRPD_MODE_DIV8 3'h6
`define PLRPD_MODE_DIV16 3'h7
`define PLRPD_HALF_DIV2 4'h1
`define PLRPD_HALF_DIV4 4'h2
`define PLRPD_HALF_DIV8 4'h4
`define PLRPD_HALF_DIV16 4'h8
`define PLRPD_HALF_NONE 4'h0
`define PLRPD_PCT_FINE0 7'h46
`define PLRPD_PCT_FINE1 7'h50
`define PLRPD_PCT_FINE2 7'h5a
`define PLRPD_PCT_COARSE0 7'h19
`define PLRPD_PCT_COARSE1 7'h32
`define PLRPD_PCT_COARSE2 7'h4b
`define PLRPD_PCT_FULL 7'h64
`define PLRPD_PRESC_LOW_DIV 65
`define PLRPD_PRESC_HIGH_DIV 64
`endif

// ==== hw/plrpd_pkg.sv ====
// Types shared by the reference divider and phase detector block.
package plrpd_pkg;
   // Configuration byte, most significant field first.
   typedef struct packed {
      logic detector_polarity_invert;
      logic sel;
      logic lock_output_enable;
      logic low_power_hold;
      logic cur_hi;
      logic cur_lo;
      logic step;
      logic spare;
   } plrpd_ctrl_s;
   // Registered detector pin levels.
   typedef struct packed {
      logic pd_val;
      logic pd_oe;
      logic ref_side_n;
      logic vco_side_n;
      logic lock;
   } plrpd_det_s;
endpackage

// ==== hw/plrpd_top.sv ====
// Reference divider, phase/frequency detector, lock output and prescaler.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "plrpd_cfg.svh"
module plrpd_top import plrpd_pkg::*; #(
   parameter int PRESC_W = 7
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Register port.
   input wire logic [`PLRPD_AW-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Reference pins.
   input wire logic reference_input_i,
   output logic reference_divided_output_o,
   output logic osc_run_o,
   output logic ref_counter_run_o,
   // Detector inputs and outputs.
   input wire logic divided_reference_pulse_i,
   input wire logic divided_vco_pulse_i,
   output logic single_ended_detector_output_o,
   output logic single_ended_detector_output_oe_o,
   output logic ref_side_detector_n_o,
   output logic vco_side_detector_n_o,
   output logic lock_detect_output_o,
   output logic [6:0] current_percent_o,
   // Prescaler.
   input wire logic prescaler_input_i,
   input wire logic modulus_ctrl_i,
   output logic prescaler_pulse_o
);

   // ************************************************************
   // Functions
   // ************************************************************

   // Half-period count in input edges for each dividing mode.
   function automatic logic [3:0] half_of(input logic [2:0] m);
      logic [3:0] h;
      h = `PLRPD_HALF_NONE;
      unique case (m)
         `PLRPD_MODE_DIV2: h = `PLRPD_HALF_DIV2;
         `PLRPD_MODE_DIV4: h = `PLRPD_HALF_DIV4;
         `PLRPD_MODE_DIV8: h = `PLRPD_HALF_DIV8;
         `PLRPD_MODE_DIV16: h = `PLRPD_HALF_DIV16;
         default: h = `PLRPD_HALF_NONE;
      endcase
      return h;
   endfunction

   // Output current in percent of maximum.
   function automatic logic [6:0] pct_of(input logic step, input logic [1:0] code);
      logic [6:0] p;
      p = `PLRPD_PCT_FULL;
      unique case (code)
         2'h0: p = step ? `PLRPD_PCT_COARSE0 : `PLRPD_PCT_FINE0;
         2'h1: p = step ? `PLRPD_PCT_COARSE1 : `PLRPD_PCT_FINE1;
         2'h2: p = step ? `PLRPD_PCT_COARSE2 : `PLRPD_PCT_FINE2;
         2'h3: p = `PLRPD_PCT_FULL;
      endcase
      return p;
   endfunction

   // ************************************************************
   // Register port
   // ************************************************************

   plrpd_ctrl_s ctrl_reg;
   logic [2:0] mode_reg;
   logic [31:0] rdata_reg;
   plrpd_det_s det_reg;
   logic up_reg;
   logic dn_reg;
   logic reference_divided_output_reg;

   wire logic hit_ctrl = (addr_i == `PLRPD_OFS_CTRL);
   wire logic hit_mode = (addr_i == `PLRPD_OFS_MODE);
   wire logic hit_stat = (addr_i == `PLRPD_OFS_STAT);
   wire logic [31:0] stat_word = {21'h0, current_percent_o, reference_divided_output_reg, det_reg.lock, dn_reg, up_reg};
   wire logic [31:0] rdata_next = hit_ctrl ? {24'h0, ctrl_reg} :
                                  hit_mode ? {29'h0, mode_reg} :
                                  hit_stat ? stat_word : 32'h0;

   // Control bits reset with the detector deselected, lock off, normal polarity.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_reg <= `PLRPD_CTRL_RST;
         mode_reg <= `PLRPD_MODE_RST;
      end else if (wr_i && hit_ctrl) begin
         ctrl_reg <= wdata_i[7:0];
      end else if (wr_i && hit_mode) begin
         mode_reg <= wdata_i[2:0];
      end
   end

   // Read data stand in the cycle after the strobe only; unmapped reads give zero.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_reg <= 32'h0;
      end else begin
         rdata_reg <= rd_i ? rdata_next : 32'h0;
      end
   end
   assign rdata_o = rdata_reg;

   // ************************************************************
   // Oscillator and reference counter control
   // ************************************************************

   // The oscillator only runs in active crystal mode, and standby never stops it.
   assign osc_run_o = (mode_reg == `PLRPD_MODE_XTAL);
   // Standby or shutdown mode halts the reference counter; in modes 2 to 7 it runs while the oscillator is off.
   assign ref_counter_run_o = (mode_reg != `PLRPD_MODE_SHUT) && !ctrl_reg.low_power_hold;

   // ************************************************************
   // Reference output divider
   // ************************************************************

   logic ref_in_d;
   logic [2:0] act_mode_reg;
   logic [3:0] div_cnt_reg;
   wire logic ref_rise = reference_input_i && !ref_in_d;
   wire logic [3:0] act_half = half_of(act_mode_reg);
   wire logic [3:0] cnt_inc = div_cnt_reg + 4'h1;
   wire logic at_half = ref_rise && (cnt_inc == act_half);
   // A new mode is taken at a half-period boundary, or at once from a non-dividing mode, so a change between dividing ratios leaves no runt pulse.
   wire logic take_mode = (act_half == `PLRPD_HALF_NONE) || at_half;
   wire logic reference_divided_output_next = (act_mode_reg == `PLRPD_MODE_FOLLOW) ? reference_input_i :
                            (act_half == `PLRPD_HALF_NONE) ? 1'b0 :
                            at_half ? !reference_divided_output_reg : reference_divided_output_reg;

   // Divider counts input rising edges and toggles every half ratio.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ref_in_d <= 1'b0;
         act_mode_reg <= `PLRPD_MODE_RST;
         div_cnt_reg <= 4'h0;
         reference_divided_output_reg <= 1'b0;
      end else begin
         ref_in_d <= reference_input_i;
         reference_divided_output_reg <= reference_divided_output_next;
         if (take_mode) begin
            act_mode_reg <= mode_reg;
            div_cnt_reg <= 4'h0;
         end else if (ref_rise) begin
            div_cnt_reg <= cnt_inc;
         end
      end
   end
   assign reference_divided_output_o = reference_divided_output_reg;

   // ************************************************************
   // Phase/frequency detector
   // ************************************************************

   logic fr_d;
   logic fv_d;
   wire logic fr_rise = divided_reference_pulse_i && !fr_d;
   wire logic fv_rise = divided_vco_pulse_i && !fv_d;
   // Both flags high for one cycle gives the short common pulse, then both clear.
   wire logic both = up_reg && dn_reg;
   wire logic up_next = !both && (up_reg || fr_rise);
   wire logic dn_next = !both && (dn_reg || fv_rise);

   // Standby clears the detector so it restarts cleanly on recovery.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fr_d <= 1'b0;
         fv_d <= 1'b0;
         up_reg <= 1'b0;
         dn_reg <= 1'b0;
      end else begin
         fr_d <= divided_reference_pulse_i;
         fv_d <= divided_vco_pulse_i;
         up_reg <= up_next && !ctrl_reg.low_power_hold;
         dn_reg <= dn_next && !ctrl_reg.low_power_hold;
      end
   end

   // ************************************************************
   // Detector outputs and lock detect
   // ************************************************************

   // Up means the vco lags (source); down means it leads (sink); both means float.
   wire logic se_en = ctrl_reg.sel && !ctrl_reg.low_power_hold;
   wire logic se_drive = se_en && (up_reg ^ dn_reg);
   wire logic se_val = ctrl_reg.detector_polarity_invert ? dn_reg : up_reg;
   wire logic de_en = !ctrl_reg.sel && !ctrl_reg.low_power_hold;
   wire logic vco_low = ctrl_reg.detector_polarity_invert ? up_reg : dn_reg;
   wire logic ref_low = ctrl_reg.detector_polarity_invert ? dn_reg : up_reg;
   wire logic vco_n_next = !(de_en && vco_low);
   wire logic ref_n_next = !(de_en && ref_low);
   wire logic lock_next = ctrl_reg.lock_output_enable && vco_n_next && ref_n_next;
   plrpd_det_s det_next;
   assign det_next = '{pd_val: se_val, pd_oe: se_drive, ref_side_n: ref_n_next,
                       vco_side_n: vco_n_next, lock: lock_next};

   // Output pins are registered; reset leaves the lock output low.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         det_reg <= '{pd_val: 1'b0, pd_oe: 1'b0, ref_side_n: 1'b1, vco_side_n: 1'b1, lock: 1'b0};
      end else begin
         det_reg <= det_next;
      end
   end
   assign single_ended_detector_output_o = det_reg.pd_val;
   assign single_ended_detector_output_oe_o = det_reg.pd_oe;
   assign ref_side_detector_n_o = det_reg.ref_side_n;
   assign vco_side_detector_n_o = det_reg.vco_side_n;
   assign lock_detect_output_o = det_reg.lock;

   // The analog stage takes this percentage of the resistor-set maximum.
   assign current_percent_o = pct_of(ctrl_reg.step, {ctrl_reg.cur_hi, ctrl_reg.cur_lo});

   // ************************************************************
   // Dual-modulus prescaler
   // ************************************************************

   localparam logic [PRESC_W-1:0] PRESC_LAST_LOW = PRESC_W'(`PLRPD_PRESC_LOW_DIV - 1);
   localparam logic [PRESC_W-1:0] PRESC_LAST_HIGH = PRESC_W'(`PLRPD_PRESC_HIGH_DIV - 1);
   logic pin_d;
   logic [PRESC_W-1:0] presc_cnt_reg;
   logic presc_pulse_reg;
   wire logic pin_rise = prescaler_input_i && !pin_d;
   // The modulus is sampled at each edge, so a change lands within the current cycle.
   wire logic [PRESC_W-1:0] presc_last = modulus_ctrl_i ? PRESC_LAST_HIGH : PRESC_LAST_LOW;
   wire logic presc_wrap = pin_rise && (presc_cnt_reg >= presc_last);

   // One output pulse per 65 or 64 input rising edges.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_d <= 1'b0;
         presc_cnt_reg <= '0;
         presc_pulse_reg <= 1'b0;
      end else begin
         pin_d <= prescaler_input_i;
         presc_pulse_reg <= presc_wrap;
         if (presc_wrap) begin
            presc_cnt_reg <= '0;
         end else if (pin_rise) begin
            presc_cnt_reg <= presc_cnt_reg + PRESC_W'(1);
         end
      end
   end
   assign prescaler_pulse_o = presc_pulse_reg;

endmodule

// ==== bench/plrpd_monitor.sv ====
// Checker of the detector, lock, register and prescaler ports.
`timescale 1ns/10ps
module plrpd_monitor #(
   parameter int PRESC_W = 7
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Register port.
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   // Watched outputs.
   input wire logic osc_run_o,
   input wire logic single_ended_detector_output_o,
   input wire logic single_ended_detector_output_oe_o,
   input wire logic ref_side_detector_n_o,
   input wire logic vco_side_detector_n_o,
   input wire logic lock_detect_output_o,
   input wire logic [6:0] current_percent_o,
   input wire logic prescaler_pulse_o
);
   // ****
   // Checks, one clock domain.
   // ****
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_lock; lock_detect_output_o |-> ref_side_detector_n_o && vco_side_detector_n_o; endproperty
   a_lock: assert property (p_lock) else $error("lock high while a side is low");
   property p_sel; single_ended_detector_output_oe_o |-> ref_side_detector_n_o && vco_side_detector_n_o; endproperty
   a_sel: assert property (p_sel) else $error("double outputs active with single output");
   property p_both; !ref_side_detector_n_o && !vco_side_detector_n_o |=> ref_side_detector_n_o; endproperty
   a_both: assert property (p_both) else $error("common low pulse too long");
   property p_pd; single_ended_detector_output_oe_o && $past(single_ended_detector_output_oe_o)
      |-> $stable(single_ended_detector_output_o); endproperty
   a_pd: assert property (p_pd) else $error("single output flipped in a pulse");
   property p_presc; prescaler_pulse_o |=> !prescaler_pulse_o [*8]; endproperty
   a_presc: assert property (p_presc) else $error("prescaler pulses too close");
   property p_rd; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
   a_rd: assert property (p_rd) else $error("read data outside its cycle");
   property p_pct; current_percent_o inside {7'h46, 7'h50, 7'h5a, 7'h64, 7'h19, 7'h32, 7'h4b}; endproperty
   a_pct: assert property (p_pct) else $error("current percent off table");
   property p_pctw; $changed(current_percent_o) |-> $past(wr_i); endproperty
   a_pctw: assert property (p_pctw) else $error("current changed without write");
   property p_osc; $changed(osc_run_o) |-> $past(wr_i); endproperty
   a_osc: assert property (p_osc) else $error("oscillator changed without write");
endmodule
bind plrpd_top plrpd_monitor #(.PRESC_W(PRESC_W)) i_mon (.*);

// ==== bench/plrpd_loop_model.sv ====
// Reference, detector pulse and prescaler sources at the far side.
`timescale 1ns/10ps
module plrpd_loop_model (
   // Clock and skew of the VCO edge ahead of the reference edge.
   input wire logic clk_i,
   input wire logic signed [31:0] lead_i,
   // Pins towards the block.
   output logic ref_o,
   output logic fr_o,
   output logic fv_o,
   output logic presc_o,
   output logic frame_o
);
   logic [4:0] cyc = 5'h00;
   initial {ref_o, fr_o, fv_o, presc_o, frame_o} = 5'h00;
   // ****
   // Frame of 32 cycles; edges sit mid-frame so skew changes at the frame start never split a pair.
   // ****
   always @(posedge clk_i) begin
      cyc <= cyc + 5'h01;
      ref_o <= cyc[3];
      fr_o <= cyc == 5'h10 || cyc == 5'h11;
      fv_o <= cyc == 5'(16 - lead_i) || cyc == 5'(17 - lead_i);
      presc_o <= ~presc_o;
      frame_o <= cyc == 5'h00;
   end
endmodule

// ==== bench/tb_pll_reference_and_phase_detect.sv ====
// Self-checking bench of the reference divider and phase detector block.
`timescale 1ns/10ps
module tb_pll_reference_and_phase_detect;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, mdl = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic reference_input, fr, fv, pin, frame, reference_divided_output, osc, ctr, pd, oe, rn, vn, lock, ppulse;
   logic [6:0] pct;
   int lead = 0, error_cnt = 0, checked = 0;
   // ****
   // Clock, block and far side.
   // ****
   always #4 clk = ~clk;
   plrpd_top i_dut (.clk_i(clk), .sys_rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .reference_input_i(reference_input), .reference_divided_output_o(reference_divided_output), .osc_run_o(osc),
      .ref_counter_run_o(ctr), .divided_reference_pulse_i(fr), .divided_vco_pulse_i(fv),
      .single_ended_detector_output_o(pd), .single_ended_detector_output_oe_o(oe),
      .ref_side_detector_n_o(rn), .vco_side_detector_n_o(vn), .lock_detect_output_o(lock),
      .current_percent_o(pct), .prescaler_input_i(pin), .modulus_ctrl_i(mdl), .prescaler_pulse_o(ppulse));
   plrpd_loop_model i_mdl (.clk_i(clk), .lead_i(lead), .ref_o(reference_input), .fr_o(fr), .fv_o(fv),
      .presc_o(pin), .frame_o(frame));
   task automatic tally_and_finish();
      $display("checked %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic bail(input int n, input int lim);
      if (n >= lim) begin
         chk(n, 0);
         tally_and_finish();
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= {24'h0, d};
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rreg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // Reset levels, register defaults and an unmapped place that keeps nothing.
   task automatic t_reset();
      logic [31:0] v;
      #1 chk({reference_divided_output, oe, rn, vn, lock, osc, ctr, pd, 1'b0, pct}, 16'h3246);
      rreg(8'h04, v);
      chk(v, 32'h6);
      wreg(8'h0c, 8'hff);
      rreg(8'h0c, v);
      chk(v, 32'h0);
      rreg(8'h00, v);
      chk(v, 32'h0);
      // Status word: flags, lock and divided output still quiet, current field at its reset value.
      rreg(8'h08, v);
      chk(v, 32'h460);
   endtask
   // Period of the divided reference between its first two rising edges, zero when held.
   task automatic t_ref(input logic [2:0] m, input int per);
      int first, gap;
      logic prev;
      wreg(8'h04, {5'h0, m});
      chk({osc, ctr}, {m == 3'h1, m != 3'h0});
      repeat (300) @(posedge clk);
      first = -1;
      gap = 0;
      prev = 1'b1;
      for (int i = 0; i < 600; i++) begin
         @(posedge clk);
         #1;
         if (reference_divided_output === 1'b1 && prev === 1'b0 && first >= 0 && gap == 0) gap = i - first;
         if (reference_divided_output === 1'b1 && prev === 1'b0 && first < 0) first = i;
         prev = reference_divided_output;
      end
      chk(gap, per);
   endtask
   task automatic wait_frame();
      int n;
      for (n = 0; n < 64 && frame !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      bail(n, 64);
   endtask
   // Low counts of each side and lock, driven and sourcing counts, over one frame.
   task automatic t_det(input logic [7:0] c, input int ld, input logic [39:0] e);
      int nv, nr, nl, no, ns;
      wait_frame();
      lead = ld;
      wreg(8'h00, c);
      wait_frame();
      {nv, nr, nl, no, ns} = '0;
      repeat (32) begin
         @(posedge clk);
         #1;
         nv += vn === 1'b0;
         nr += rn === 1'b0;
         nl += lock === 1'b0;
         no += oe === 1'b1;
         ns += oe === 1'b1 && pd === 1'b1;
      end
      chk({8'(nv), 8'(nr), 8'(nl), 8'(no), 8'(ns)}, e);
   endtask
   task automatic wait_pulse(output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (ppulse !== 1'b1 && n < 300);
      bail(n, 300);
   endtask
   // Standby keeps the oscillator but stops the counter; shutdown stops both.
   task automatic t_osc();
      wreg(8'h04, 8'h01);
      wreg(8'h00, 8'h10);
      chk({osc, ctr}, 2'b10);
      wreg(8'h04, 8'h00);
      chk({osc, ctr}, 2'b00);
   endtask
   // Every current code under both step sizes.
   task automatic t_pct();
      logic [6:0] tab [8] = '{7'h46, 7'h19, 7'h50, 7'h32, 7'h5a, 7'h4b, 7'h64, 7'h64};
      for (int i = 0; i < 8; i++) begin
         wreg(8'h00, {4'h0, i[2:0], 1'b0});
         chk(pct, tab[i]);
      end
   endtask
   // Prescaler period under each modulus, measured after one settling pulse.
   task automatic t_presc();
      int n;
      for (int m = 0; m < 2; m++) begin
         @(posedge clk);
         mdl <= m[0];
         wait_pulse(n);
         wait_pulse(n);
         chk(n, m == 0 ? 130 : 128);
      end
   endtask
   // ****
   // Main sequence.
   // ****
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      for (int m = 0; m < 8; m++) t_ref(m[2:0], m < 3 ? 0 : 16 << (m - 3));
      t_osc();
      t_pct();
      t_det(8'h20, 4, 40'h0501050000);
      t_det(8'h20, -4, 40'h0105050000);
      t_det(8'ha0, 4, 40'h0105050000);
      t_det(8'h00, 0, 40'h0101200000);
      t_det(8'h60, 4, 40'h0000000400);
      t_det(8'h60, -4, 40'h0000000404);
      t_det(8'he0, 4, 40'h0000000404);
      t_det(8'h70, 4, 40'h0000000000);
      t_det(8'h30, -4, 40'h0000000000);
      t_presc();
      tally_and_finish();
   end
endmodule
